/* core/ttf_map.vh */
// register map, field positions, codes and timing constants of the trip block
`ifndef TTF_MAP_VH
`define TTF_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define TTF_CTRL      8'h00
`define TTF_STAT      8'h04
`define TTF_EVACT     8'h08
`define TTF_CAUSE     8'h0c
`define TTF_REFLIM    8'h10
`define TTF_RATES     8'h14
`define TTF_SPDREF    8'h18
`define TTF_SW0       8'h1c
`define TTF_SW1       8'h20
`define TTF_SW2       8'h24
`define TTF_HSSPD     8'h28
`define TTF_OVSSP     8'h2c
`define TTF_STEMP     8'h30
`define TTF_SRATE     8'h34
`define TTF_EGTSP     8'h38
`define TTF_ETRL      8'h3c
`define TTF_ACCSP     8'h40
`define TTF_CURVE     8'h80
`define TTF_CURVE_N   5'd20
// ****************************************
// control bits
// ****************************************
`define TTF_C_LIQ     0
`define TTF_C_DUAL    1
`define TTF_C_OVST    2
`define TTF_C_PROBE   3
`define TTF_C_STEMP   4
`define TTF_C_ACCV    5
`define TTF_C_RATE    7:6
`define TTF_C_RAISE   8
`define TTF_C_LOWER   9
`define TTF_RATE_FAST 2'h1
`define TTF_RATE_INST 2'h2
// ****************************************
// action codes and reset values
// ****************************************
`define TTF_ACT_DIS   3'h1
`define TTF_ACT_ALM   3'h2
`define TTF_ACT_SOFT  3'h3
`define TTF_ACT_HARD  3'h4
`define TTF_ACT_USER  3'h5
`define TTF_EVACT_RST 32'h00492492
`define TTF_REF_RST   32'h0e100bb8
`define TTF_RATE_RST  32'h0064000a
`define TTF_SPD_RST   16'h01f4
`define TTF_OVS_RST   16'hffff
`define TTF_PT_LAST   3'h4
`define TTF_CURVES    4'ha
// ****************************************
// timing
// ****************************************
`define TTF_CLK_NS    50
`define TTF_TICK_NS   1000000
`define TTF_MILLI     32'h000003e8
`endif

/* core/ttf_sync3.v */
// three-stage input synchroniser with agreement filter
module ttf_sync3 #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         ce,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   wire [W-1:0] agree = ~(s2_r ^ s3_r);
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         q    <= {W{1'b0}};
      end
      else if (ce)
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // change only once stages two and three agree
         q    <= (agree & s3_r) | (~agree & q);
      end
   end
endmodule

/* core/ttf_curve_mem.v */
// breakpoint store for limiter curves, registered read
module ttf_curve_mem #(
   parameter AW    = 5,
   parameter DW    = 24,
   parameter DEPTH = 20
) (
   input  wire          clk,
   input  wire          ce,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:DEPTH-1];
   always @(posedge clk)
   begin
      if (ce)
      begin
         if (we)
            mem[waddr] <= wdata;
         rdata <= mem[raddr];
      end
   end
endmodule

/* core/ttf_core.v */
// trip latching, speed reference, speed switches and fuel limiter selection
//
// Overview of operation
// - soft shutdown opens generator breaker, fuel left alone
// - first soft, first hard and last shutdown cause codes readable over the register bus
// - acknowledge silences horn, latches stay set
// - reset clears soft latch only once its condition is gone
// - hard latch clears on reset only if condition gone and speed low
// - hard shutdown suppresses later soft events
// - first-out codes; soft shown with hard only if soft came first
// - hard shutdown zeroes valve demand, closes shutoff valves, opens breaker
// - summary relay on while any hard shutdown is latched
// - speed reference ramps between limits at default, fast or instant rate
// - three speed switches compare speed to own setpoints
// - dual dynamics picks gain set from droop or isochronous mode
// - overspeed setpoint writable in running unit only under test enable
// - failed probe indication suppressed until speed is expected
// - accel limit from rate controller or pressure curve
// - accel curve caps valve demand from above
// - decel curve sets floor for valve demand
// - separate curve sets per fuel, active fuel chooses
// - decel curve five breakpoints evaluated in order one to five
// - start temperature setpoint ramps low to high at configured rate
// - temperature loop reverts to topping once speed control reached
// - least fuel demand among limiters wins
// - each event has action code: disabled, alarm, soft, hard, user
//
// Implementation choices: the APB register port and the register addresses.
`include "ttf_map.vh"
module ttf_core #(
   parameter NEV      = 8,
   parameter TICK_CYC = `TTF_TICK_NS / `TTF_CLK_NS
) (
   input  wire           clk,
   input  wire           rst_n,
   input  wire           ce,
   input  wire [7:0]     paddr,
   input  wire           psel,
   input  wire           penable,
   input  wire           pwrite,
   input  wire [31:0]    pwdata,
   output reg  [31:0]    prdata,
   output wire           pready,
   output reg            pslverr,
   input  wire [NEV-1:0] evt_in,
   input  wire           ack_in,
   input  wire           reset_in,
   input  wire [15:0]    pt_speed,
   input  wire [15:0]    compressor_discharge_pressure,
   input  wire           pt_in_control,
   input  wire           droop_mode,
   input  wire           speed_expected,
   input  wire           probe_fail,
   input  wire           fuel_sov_req,
   input  wire [7:0]     speed_dmd,
   input  wire [7:0]     accel_pid_dmd,
   input  wire [7:0]     egt_dmd,
   input  wire [7:0]     egt_rate_dmd,
   output reg            breaker_open,
   output reg            fuel_sov_open,
   output reg  [7:0]     valve_dmd,
   output reg            horn,
   output reg            summary_sd_relay,
   output reg            alarm_relay,
   output reg  [2:0]     spd_sw,
   output reg            gain_set_sel,
   output reg            probe_fail_ind,
   output reg  [15:0]    spd_ref,
   output reg  [15:0]    egt_setpoint,
   output reg  [15:0]    exhaust_temp_rate_limit,
   output reg  [15:0]    accel_rate_sp
);
   localparam NE = NEV + 1;
   // ****************************************
   // registers
   // ****************************************
   reg  [9:0]  ctrl_r;
   reg  [31:0] evact_r;
   reg  [31:0] reflim_r;
   reg  [31:0] rates_r;
   reg  [15:0] sw_sp_r [0:2];
   reg  [15:0] hsspd_r;
   reg  [15:0] ovs_sp_r;
   reg  [31:0] stemp_r;
   reg  [15:0] srate_r;
   reg  [15:0] egtsp_r;
   reg  [NE-1:0] soft_lat_r;
   reg  [NE-1:0] hard_lat_r;
   reg  [NE-1:0] alm_lat_r;
   reg  [7:0]  first_soft_r;
   reg  [7:0]  first_hard_r;
   reg  [7:0]  last_code_r;
   reg         ack_d_r;
   reg         rst_d_r;
   reg  [31:0] ref_m_r;
   reg  [31:0] egt_m_r;
   reg         topping_r;
   reg  [31:0] tick_cnt_r;
   reg  [3:0]  rd_cnt_r;
   reg  [3:0]  vd_cnt_r;
   reg         vd_r;
   reg         found_r;
   reg  [7:0]  ysel_r;
   reg  [7:0]  accel_y_r;
   reg  [7:0]  decel_y_r;
   wire [NEV+1:0] sync_q;
   wire [23:0] crv_q;
   // ****************************************
   // input synchronisers and curve store
   // ****************************************
   ttf_sync3 #(.W(NEV + 2)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({reset_in, ack_in, evt_in}),
      .q     (sync_q)
   );
   wire [NEV-1:0] evt_f  = sync_q[NEV-1:0];
   wire           ack_f  = sync_q[NEV];
   wire           rst_f  = sync_q[NEV+1];
   wire           ack_p  = ack_f & ~ack_d_r;
   wire           rst_p  = rst_f & ~rst_d_r;
   wire           wr     = psel & penable & pwrite;
   wire [4:0]     crv_wa = paddr[6:2];
   wire           crv_hit = (paddr >= `TTF_CURVE) && (crv_wa < `TTF_CURVE_N);
   wire           liq    = ctrl_r[`TTF_C_LIQ];
   wire [4:0]     crv_ra = (liq ? {1'b0, `TTF_CURVES} : 5'h00) + {1'b0, rd_cnt_r};
   ttf_curve_mem #(.AW(5), .DW(24), .DEPTH(20)) u_mem (
      .clk   (clk),
      .ce    (ce),
      .we    (wr & crv_hit),
      .waddr (crv_wa),
      .wdata (pwdata[23:0]),
      .raddr (crv_ra),
      .rdata (crv_q)
   );
   // ****************************************
   // event classification
   // ****************************************
   wire           ovs_cond = pt_speed > ovs_sp_r;
   wire [NE-1:0]  cond     = {ovs_cond, evt_f};
   wire           any_hard = |hard_lat_r;
   wire           any_soft = |soft_lat_r;
   wire           spd_low  = pt_speed < hsspd_r;
   reg  [NE-1:0]  is_hard;
   reg  [NE-1:0]  is_soft;
   reg  [NE-1:0]  is_alm;
   reg  [2:0]     act;
   integer        i;
   always @*
   begin
      act = `TTF_ACT_DIS;
      for (i = 0; i < NE; i = i + 1)
      begin
         // overspeed trip is always a hard shutdown
         act = (i == NEV) ? `TTF_ACT_HARD : evact_r[3*i +: 3];
         is_hard[i] = (act == `TTF_ACT_HARD);
         is_soft[i] = (act == `TTF_ACT_SOFT);
         is_alm[i]  = (act == `TTF_ACT_ALM);
      end
   end
   wire [NE-1:0] hard_set = cond & is_hard;
   wire [NE-1:0] soft_set = cond & is_soft & {NE{~any_hard}};
   wire [NE-1:0] alm_set  = cond & is_alm;
   wire [NE-1:0] hard_new = hard_set & ~hard_lat_r;
   wire [NE-1:0] soft_new = soft_set & ~soft_lat_r;
   wire [NE-1:0] alm_new  = alm_set & ~alm_lat_r;
   wire [NE-1:0] clr_ok   = {NE{rst_p}} & ~cond;
   // lowest index of a vector as code, index plus one
   function [7:0] code_of;
      input [NE-1:0] v;
      integer k;
      begin
         code_of = 8'h00;
         for (k = NE - 1; k >= 0; k = k - 1)
            if (v[k])
               code_of = k[7:0] + 8'h01;
      end
   endfunction
   // ****************************************
   // latches, horn, first-out
   // ****************************************
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         soft_lat_r   <= {NE{1'b0}};
         hard_lat_r   <= {NE{1'b0}};
         alm_lat_r    <= {NE{1'b0}};
         horn         <= 1'b0;
         first_soft_r <= 8'h00;
         first_hard_r <= 8'h00;
         last_code_r  <= 8'h00;
         ack_d_r      <= 1'b0;
         rst_d_r      <= 1'b0;
      end
      else if (ce)
      begin
         ack_d_r    <= ack_f;
         rst_d_r    <= rst_f;
         // set wins over reset in the same cycle
         soft_lat_r <= soft_set | (soft_lat_r & ~clr_ok);
         alm_lat_r  <= alm_set | (alm_lat_r & ~clr_ok);
         hard_lat_r <= hard_set | (hard_lat_r & ~(clr_ok & {NE{spd_low}}));
         if (any_hard)
            soft_lat_r <= {NE{1'b0}};
         if (|(hard_new | soft_new | alm_new))
            horn <= 1'b1;
         else if (ack_p)
            horn <= 1'b0;
         if (|hard_new)
            last_code_r <= code_of(hard_new);
         else if (|soft_new)
            last_code_r <= code_of(soft_new);
         // soft first-out only when no shutdown of any kind preceded it
         if (!any_hard && !any_soft && |soft_new && !(|hard_new))
            first_soft_r <= code_of(soft_new);
         else if (!any_soft && !any_hard)
            first_soft_r <= 8'h00;
         if (!any_hard && |hard_new)
            first_hard_r <= code_of(hard_new);
         else if (!any_hard)
            first_hard_r <= 8'h00;
      end
   end
   // ****************************************
   // trip outputs
   // ****************************************
   wire [7:0] least_fuel_select_bus;
   wire [7:0] fin;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         breaker_open     <= 1'b0;
         fuel_sov_open    <= 1'b0;
         valve_dmd        <= 8'h00;
         summary_sd_relay <= 1'b0;
         alarm_relay      <= 1'b0;
         gain_set_sel     <= 1'b0;
         probe_fail_ind   <= 1'b0;
      end
      else if (ce)
      begin
         breaker_open     <= any_soft | any_hard;
         fuel_sov_open    <= fuel_sov_req & ~any_hard;
         valve_dmd        <= any_hard ? 8'h00 : fin;
         summary_sd_relay <= any_hard;
         alarm_relay      <= |(alm_lat_r | soft_lat_r | hard_lat_r);
         gain_set_sel     <= ctrl_r[`TTF_C_DUAL] & droop_mode;
         probe_fail_ind   <= probe_fail &
                             (speed_expected | ~ctrl_r[`TTF_C_PROBE]);
      end
   end
   // ****************************************
   // ramp tick
   // ****************************************
   wire tick = (tick_cnt_r == TICK_CYC - 1);
   always @(posedge clk)
   begin
      if (!rst_n)
         tick_cnt_r <= 32'h00000000;
      else if (ce)
         tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
   end
   // ****************************************
   // speed reference, milli-rpm held
   // ****************************************
   wire [31:0] lo_m   = {16'h0000, reflim_r[15:0]} * `TTF_MILLI;
   wire [31:0] hi_m   = {16'h0000, reflim_r[31:16]} * `TTF_MILLI;
   wire [1:0]  rsel   = ctrl_r[`TTF_C_RATE];
   wire [31:0] rate   = {16'h0000, (rsel == `TTF_RATE_FAST) ? rates_r[31:16]
                                                            : rates_r[15:0]};
   wire        inst   = (rsel == `TTF_RATE_INST);
   wire [31:0] ref_q  = ref_m_r / `TTF_MILLI;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         ref_m_r <= 32'h00000000;
         spd_ref <= 16'h0000;
      end
      else if (ce)
      begin
         spd_ref <= ref_q[15:0];
         if (any_hard)
            ref_m_r <= lo_m;
         else if (ctrl_r[`TTF_C_RAISE] && inst)
            ref_m_r <= hi_m;
         else if (ctrl_r[`TTF_C_LOWER] && inst)
            ref_m_r <= lo_m;
         else if (ctrl_r[`TTF_C_RAISE] && tick)
            ref_m_r <= (ref_m_r + rate >= hi_m) ? hi_m : ref_m_r + rate;
         else if (ctrl_r[`TTF_C_LOWER] && tick)
            ref_m_r <= (ref_m_r <= lo_m + rate) ? lo_m : ref_m_r - rate;
         else if (ref_m_r < lo_m)
            ref_m_r <= lo_m;
         else if (ref_m_r > hi_m)
            ref_m_r <= hi_m;
      end
   end
   // ****************************************
   // speed switches
   // ****************************************
   wire [2:0] sw_hit;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_sw
         assign sw_hit[g] = (pt_speed >= sw_sp_r[g]);
      end
   endgenerate
   always @(posedge clk)
   begin
      if (!rst_n)
         spd_sw <= 3'h0;
      else if (ce)
         spd_sw <= sw_hit;
   end
   // ****************************************
   // exhaust temperature setpoint
   // ****************************************
   wire [31:0] tlo_m = {16'h0000, stemp_r[15:0]} * `TTF_MILLI;
   wire [31:0] thi_m = {16'h0000, stemp_r[31:16]} * `TTF_MILLI;
   wire [31:0] trate = {16'h0000, srate_r};
   wire [31:0] egt_q = egt_m_r / `TTF_MILLI;
   wire        start_lim = ctrl_r[`TTF_C_STEMP] & ~topping_r;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         egt_m_r      <= 32'h00000000;
         topping_r    <= 1'b0;
         egt_setpoint <= 16'h0000;
      end
      else if (ce)
      begin
         if (any_hard)
            topping_r <= 1'b0;
         else if (pt_in_control)
            topping_r <= 1'b1;
         if (!start_lim || any_hard)
            egt_m_r <= tlo_m;
         else if (tick)
            egt_m_r <= (egt_m_r + trate >= thi_m) ? thi_m : egt_m_r + trate;
         egt_setpoint <= start_lim ? egt_q[15:0] : egtsp_r;
      end
   end
   // ****************************************
   // curve walker, points in order
   // ****************************************
   wire [2:0] pt     = (vd_cnt_r < 4'h5) ? vd_cnt_r[2:0] : vd_cnt_r[2:0] - 3'h5;
   wire       pt0    = (pt == 3'h0);
   wire       was_f  = pt0 ? 1'b0 : found_r;
   wire       hit    = ~was_f & ((compressor_discharge_pressure <= crv_q[15:0]) | (pt == `TTF_PT_LAST));
   wire [7:0] y_now  = hit ? crv_q[23:16] : ysel_r;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_cnt_r  <= 4'h0;
         vd_cnt_r  <= 4'h0;
         vd_r      <= 1'b0;
         found_r   <= 1'b0;
         ysel_r    <= 8'h00;
         accel_y_r <= 8'h00;
         decel_y_r <= 8'h00;
      end
      else if (ce)
      begin
         rd_cnt_r <= (rd_cnt_r == `TTF_CURVES - 4'h1) ? 4'h0 : rd_cnt_r + 4'h1;
         vd_cnt_r <= rd_cnt_r;
         vd_r     <= 1'b1;
         if (vd_r)
         begin
            found_r <= was_f | hit;
            ysel_r  <= y_now;
            if (pt == `TTF_PT_LAST && vd_cnt_r < 4'h5)
               accel_y_r <= y_now;
            if (pt == `TTF_PT_LAST && vd_cnt_r >= 4'h5)
               decel_y_r <= y_now;
         end
      end
   end
   // ****************************************
   // least fuel select and floor
   // ****************************************
   wire [7:0] acc_lim = ctrl_r[`TTF_C_ACCV] ? accel_y_r : accel_pid_dmd;
   wire [7:0] m1      = (speed_dmd < acc_lim) ? speed_dmd : acc_lim;
   wire [7:0] m2      = (egt_dmd < egt_rate_dmd) ? egt_dmd : egt_rate_dmd;
   assign least_fuel_select_bus = (m1 < m2) ? m1 : m2;
   assign fin = (least_fuel_select_bus < decel_y_r) ? decel_y_r : least_fuel_select_bus;
   // ****************************************
   // register bus
   // ****************************************
   assign pready = 1'b1;
   wire running  = (pt_speed != 16'h0000);
   reg  [31:0] rd_v;
   reg         rd_err;
   always @*
   begin
      rd_err = 1'b0;
      case (paddr)
         `TTF_CTRL:   rd_v = {22'h000000, ctrl_r};
         `TTF_STAT:   rd_v = {20'h00000, probe_fail_ind, spd_sw, gain_set_sel,
                              topping_r, fuel_sov_open, breaker_open, horn,
                              |alm_lat_r, any_hard, any_soft};
         `TTF_EVACT:  rd_v = evact_r;
         `TTF_CAUSE:  rd_v = {8'h00, last_code_r, first_hard_r, first_soft_r};
         `TTF_REFLIM: rd_v = reflim_r;
         `TTF_RATES:  rd_v = rates_r;
         `TTF_SPDREF: rd_v = {16'h0000, spd_ref};
         `TTF_SW0:    rd_v = {16'h0000, sw_sp_r[0]};
         `TTF_SW1:    rd_v = {16'h0000, sw_sp_r[1]};
         `TTF_SW2:    rd_v = {16'h0000, sw_sp_r[2]};
         `TTF_HSSPD:  rd_v = {16'h0000, hsspd_r};
         `TTF_OVSSP:  rd_v = {16'h0000, ovs_sp_r};
         `TTF_STEMP:  rd_v = stemp_r;
         `TTF_SRATE:  rd_v = {16'h0000, srate_r};
         `TTF_EGTSP:  rd_v = {16'h0000, egtsp_r};
         `TTF_ETRL:   rd_v = {16'h0000, exhaust_temp_rate_limit};
         `TTF_ACCSP:  rd_v = {16'h0000, accel_rate_sp};
         default:
         begin
            rd_v   = 32'h00000000;
            rd_err = ~crv_hit;
         end
      endcase
   end
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         prdata                  <= 32'h00000000;
         pslverr                 <= 1'b0;
         ctrl_r                  <= 10'h000;
         evact_r                 <= `TTF_EVACT_RST;
         reflim_r                <= `TTF_REF_RST;
         rates_r                 <= `TTF_RATE_RST;
         sw_sp_r[0]              <= `TTF_SPD_RST;
         sw_sp_r[1]              <= `TTF_SPD_RST;
         sw_sp_r[2]              <= `TTF_SPD_RST;
         hsspd_r                 <= `TTF_SPD_RST;
         ovs_sp_r                <= `TTF_OVS_RST;
         stemp_r                 <= 32'h00000000;
         srate_r                 <= 16'h0000;
         egtsp_r                 <= 16'h0000;
         exhaust_temp_rate_limit <= 16'h0000;
         accel_rate_sp           <= 16'h0000;
      end
      else if (ce)
      begin
         if (psel && !penable)
         begin
            prdata  <= pwrite ? 32'h00000000 : rd_v;
            pslverr <= rd_err;
         end
         if (wr)
         begin
            case (paddr)
               `TTF_CTRL:   ctrl_r <= pwdata[9:0];
               `TTF_EVACT:  evact_r <= pwdata;
               `TTF_REFLIM: reflim_r <= pwdata;
               `TTF_RATES:  rates_r <= pwdata;
               `TTF_SW0:    sw_sp_r[0] <= pwdata[15:0];
               `TTF_SW1:    sw_sp_r[1] <= pwdata[15:0];
               `TTF_SW2:    sw_sp_r[2] <= pwdata[15:0];
               `TTF_HSSPD:  hsspd_r <= pwdata[15:0];
               `TTF_OVSSP:
               begin
                  if (ctrl_r[`TTF_C_OVST] || !running)
                     ovs_sp_r <= pwdata[15:0];
               end
               `TTF_STEMP:  stemp_r <= pwdata;
               `TTF_SRATE:  srate_r <= pwdata[15:0];
               `TTF_EGTSP:  egtsp_r <= pwdata[15:0];
               `TTF_ETRL:   exhaust_temp_rate_limit <= pwdata[15:0];
               `TTF_ACCSP:  accel_rate_sp <= pwdata[15:0];
               default:     ctrl_r <= ctrl_r;
            endcase
         end
      end
   end
endmodule

/* verif/ttf_core_properties.sv */
// checker of the trip outputs of the trip block
module ttf_core_props (
   input logic       clk,
   input logic       rst_n,
   input logic       psel,
   input logic       penable,
   input logic       pready,
   input logic       ack_in,
   input logic       reset_in,
   input logic       horn,
   input logic       summary_sd_relay,
   input logic       alarm_relay,
   input logic       breaker_open,
   input logic       fuel_sov_open,
   input logic [7:0] valve_dmd
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***
   // properties
   // ***
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sov_closed_a: assert property (summary_sd_relay |-> !fuel_sov_open)
      else $error("fuel valve open during trip");
   dmd_zero_a: assert property (summary_sd_relay |-> valve_dmd == 8'h00)
      else $error("valve demand not zero during trip");
   brk_open_a: assert property (summary_sd_relay |-> breaker_open)
      else $error("breaker closed during trip");
   relay_horn_a: assert property ($rose(summary_sd_relay) |-> horn)
      else $error("horn silent at trip");
   relay_alarm_a: assert property (summary_sd_relay |-> alarm_relay)
      else $error("alarm relay off during trip");
   relay_holds_a: assert property (!reset_in [*8] ##1 summary_sd_relay |=> summary_sd_relay)
      else $error("trip relay dropped without reset");
   horn_quiet_a: assert property (summary_sd_relay && $rose(ack_in) |-> ##[1:8] !horn)
      else $error("horn not silenced");
   zero_wait_a: assert property (psel && penable |-> pready)
      else $error("bus access stalled");
   cover property ($rose(summary_sd_relay));
   cover property ($fell(summary_sd_relay));
   cover property ($rose(ack_in) && horn);
endmodule

bind ttf_core ttf_core_props i_props (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pready(pready), .ack_in(ack_in), .reset_in(reset_in), .horn(horn),
   .summary_sd_relay(summary_sd_relay), .alarm_relay(alarm_relay),
   .breaker_open(breaker_open), .fuel_sov_open(fuel_sov_open), .valve_dmd(valve_dmd));

/* verif/ttf_plant.sv */
// turbine speed model driven by the fuel shutoff valve
module ttf_plant (
   input  logic        clk,
   input  logic        rst_n,
   input  logic        fuel_sov_open,
   output logic [15:0] pt_speed
);
   timeunit 1ns;
   timeprecision 1ns;
   // spins up on fuel, coasts down without
   always @(posedge clk)
      if (!rst_n)
         pt_speed <= 16'h0000;
      else if (fuel_sov_open && pt_speed < 16'd3000)
         pt_speed <= pt_speed + 16'd4;
      else if (!fuel_sov_open && pt_speed != 16'h0000)
         pt_speed <= pt_speed - 16'd4;
endmodule

/* verif/tb.sv */
// self-checking bench of the trip block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, psel, penable, pwrite, ack_in, reset_in, fuel_sov_req, e;
   logic [7:0]  paddr, evt_in, dmd;
   logic [3:0]  mode;
   logic [31:0] pwdata, q;
   wire  [31:0] prdata;
   wire         pready, pslverr, breaker_open, fuel_sov_open, horn, summary_sd_relay;
   wire         alarm_relay, gain_set_sel, probe_fail_ind;
   wire  [2:0]  spd_sw;
   wire  [7:0]  valve_dmd;
   wire  [15:0] pt_speed, spd_ref;
   int          err_total, cmp_count, cyc;

   ttf_core #(.TICK_CYC(4)) i_dut (.clk, .rst_n, .ce(1'b1), .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .evt_in, .ack_in, .reset_in,
      .pt_speed, .compressor_discharge_pressure(pt_speed), .pt_in_control(mode[0]), .droop_mode(mode[1]),
      .speed_expected(mode[2]), .probe_fail(mode[3]), .fuel_sov_req, .speed_dmd(dmd),
      .accel_pid_dmd(dmd), .egt_dmd(dmd), .egt_rate_dmd(dmd), .breaker_open,
      .fuel_sov_open, .valve_dmd, .horn, .summary_sd_relay, .alarm_relay, .spd_sw,
      .gain_set_sel, .probe_fail_ind, .spd_ref, .egt_setpoint(),
      .exhaust_temp_rate_limit(), .accel_rate_sp());
   ttf_plant i_plant (.clk, .rst_n, .fuel_sov_open, .pt_speed);

   // ***
   // helpers
   // ***
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task pulse(input logic r);
      if (r) reset_in <= 1'b1;
      else ack_in <= 1'b1;
      repeat (8) @(posedge clk);
      reset_in <= 1'b0;
      ack_in <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task test_done;
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ***
   // scenarios
   // ***
   task t_regs;
      apb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h00492492);
      apb(1'b0, 8'h1c, 32'h0);
      chk(q, 32'h000001f4);
      apb(1'b0, 8'hfc, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk({16'h0, spd_ref}, 32'hbb8);
      apb(1'b1, 8'h94, 32'h0050ffff);
      repeat (30) @(posedge clk);
      chk({24'h0, valve_dmd}, 32'h50);
      $display("test regs done");
   endtask
   task t_hard;
      apb(1'b1, 8'h08, 32'h0049249c);
      while (pt_speed < 16'd3000) @(posedge clk);
      evt_in <= 8'h01;
      while (summary_sd_relay !== 1'b1) @(posedge clk);
      chk({29'h0, breaker_open, fuel_sov_open, horn}, 32'h5);
      chk({24'h0, valve_dmd}, 32'h0);
      chk({28'h0, alarm_relay, spd_sw}, 32'hf);
      apb(1'b0, 8'h0c, 32'h0);
      chk(q, 32'h00010100);
      pulse(1'b0);
      chk({30'h0, horn, summary_sd_relay}, 32'h1);
      pulse(1'b1);
      chk({31'h0, summary_sd_relay}, 32'h1);
      evt_in <= 8'h00;
      pulse(1'b1);
      chk({31'h0, summary_sd_relay}, 32'h1);
      while (pt_speed >= 16'd500) @(posedge clk);
      pulse(1'b1);
      chk({31'h0, summary_sd_relay}, 32'h0);
      $display("test hard done");
   endtask
   task t_soft;
      evt_in <= 8'h02;
      while (breaker_open !== 1'b1) @(posedge clk);
      chk({30'h0, fuel_sov_open, summary_sd_relay}, 32'h2);
      pulse(1'b1);
      chk({31'h0, breaker_open}, 32'h1);
      evt_in <= 8'h00;
      pulse(1'b1);
      chk({31'h0, breaker_open}, 32'h0);
      evt_in <= 8'h02;
      while (breaker_open !== 1'b1) @(posedge clk);
      evt_in <= 8'h03;
      while (summary_sd_relay !== 1'b1) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk({30'h0, q[1:0]}, 32'h2);
      apb(1'b0, 8'h0c, 32'h0);
      chk(q, 32'h00010102);
      evt_in <= 8'h00;
      while (pt_speed >= 16'd500) @(posedge clk);
      pulse(1'b1);
      chk({31'h0, breaker_open}, 32'h0);
      $display("test soft done");
   endtask
   task t_mode;
      apb(1'b1, 8'h00, 32'h0000018a);
      mode <= 4'ha;
      repeat (4) @(posedge clk);
      chk({14'h0, gain_set_sel, probe_fail_ind, spd_ref}, 32'h20e10);
      $display("test mode done");
   endtask

   // ***
   // clock, timeout and main sequence
   // ***
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         test_done;
      end
   end
   initial
   begin
      {rst_n, psel, penable, pwrite, ack_in, reset_in} = 6'h0;
      {paddr, evt_in, pwdata} = 48'h0;
      fuel_sov_req = 1'b1;
      dmd = 8'h40;
      mode = 4'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_hard;
      t_soft;
      t_mode;
      test_done;
   end
endmodule
